//--- pfc_phy_control.sv
// Transceiver function control register bank behind a classic Wishbone slave
//
// Operation
// - Bit 15 enables auto crossover, resets one
// - Bit 14 forces crossed pairs, resets zero
// - Bit 13 resolved pause receive, full duplex only
// - Bit 12 resolved pause transmit, full duplex only
// - Bit 11 injects one error, self clears
// - Bit 9 pass flag, cleared by failure/stop
// - Bit 8 starts self-test; bit 10 picks sequence
// - Writing zero to bit 8 stops, clears pass
// - Bit 8 reads one only with traffic seen
// - Bit 7 bypasses LED stretching, resets zero
// - Broadcast write keeps port address unchanged
`timescale 1ns/1ps
module pfc_phy_control
  import pfc_pkg::*;
#(
  parameter int ADDR_W = 10
) (
  input wire logic clk,
  input wire logic rst,
  input wire logic ce,
  input wire logic cyc_i,
  input wire logic stb_i,
  input wire logic we_i,
  input wire logic [ADDR_W-1:0] adr_i,
  input wire logic [3:0] sel_i,
  input wire logic [31:0] dat_i,
  output logic [31:0] dat_o,
  output logic ack_o,
  input wire logic [1:0] localAdvPause,
  input wire logic [1:0] partnerAdvPause,
  input wire logic fullDuplexHcd,
  input wire logic selftestFail,
  input wire logic selftestRxTraffic,
  input wire logic [4:0] portAddressStrap,
  output logic autoCrossoverEnable,
  output logic forceCrossover,
  output logic selftestForceError,
  output logic selftestSequenceSelect,
  output logic selftestEnable,
  output logic ledStretchBypass,
  output logic [1:0] ledConfig,
  output logic [4:0] portAddress,
  output logic pauseRxEnable,
  output logic pauseTxEnable
);
  import pfc_pkg::*;

  // Registered state and its next value
  pfc_state_t state_reg;
  pfc_state_t state_next;

  // Reset image of the state
  // Pause, pass and strap fields start at zero until logic fills them
  localparam pfc_state_t PFC_STATE_RST = '{
    autoXo: PFC_RST_AUTO_XO,
    ledCnfg: PFC_RST_LED_CFG,
    default: '0
  };

  // Strap pins come from outside, so they are synchronised first
  logic [4:0] strapSync;

  pfc_sync #(
    .W(5)
  ) u_strap_sync (
    .clk(clk),
    .rst(rst),
    .ce(ce),
    .d(portAddressStrap),
    .q(strapSync)
  );

  // Bus decode helpers
  logic reqLive;   // Request present this cycle
  logic accept;    // New request, not yet acknowledged
  logic hitReg;    // Direct register address
  logic hitBcast;  // Broadcast alias address
  logic wrNow;     // Write commits at the edge the master sees ack
  logic resRx;     // Pause receive before duplex qualification
  logic resTx;     // Pause transmit before duplex qualification
  logic [15:0] regView; // Word as software reads it

  // Address compare uses every bit, so other slots miss both decodes
  assign reqLive = cyc_i & stb_i;
  assign accept = reqLive & ~state_reg.ack;
  assign hitReg = (adr_i == ADDR_W'(PFC_FUNC_ADDR));
  assign hitBcast = (adr_i == ADDR_W'(PFC_BCAST_ADDR));
  assign wrNow = reqLive & we_i & state_reg.ack & (hitReg | hitBcast);

  // Writes commit late on purpose: the master still holds address and
  // data at the ack edge, so the commit never sees a half-changed request

  // Symmetric pause on both ends, or asymmetric direction match
  // Index 0 is the symmetric pause bit, index 1 the asymmetric one
  // Resolution stays combinational; only the registered copy leaves
  assign resTx = (localAdvPause[0] & partnerAdvPause[0]) |
                 (~localAdvPause[0] & localAdvPause[1] &
                  partnerAdvPause[0] & partnerAdvPause[1]);
  assign resRx = (localAdvPause[0] & partnerAdvPause[0]) |
                 (localAdvPause[0] & localAdvPause[1] &
                  ~partnerAdvPause[0] & partnerAdvPause[1]);

  // Read image of the register
  // Bit 8 reads the live traffic level, so a read sees it drop at once
  always_comb begin
    regView = 16'h0000;
    regView[PFC_B_AUTO_XO] = state_reg.autoXo;
    regView[PFC_B_FORCE_XO] = state_reg.forceXo;
    regView[PFC_B_PAUSE_RX] = state_reg.pauseRx;
    regView[PFC_B_PAUSE_TX] = state_reg.pauseTx;
    regView[PFC_B_FORCE_ERR] = state_reg.forceErr;
    regView[PFC_B_SEQ_SEL] = state_reg.seqSel;
    regView[PFC_B_PASS] = state_reg.passFlag;
    // Run reads active only once the checker sees traffic
    regView[PFC_B_RUN] = state_reg.run & selftestRxTraffic;
    regView[PFC_B_LED_BYP] = state_reg.ledBypass;
    regView[PFC_B_LED_CFG +: 2] = state_reg.ledCnfg;
    regView[PFC_B_PORT_ADDR +: 5] = state_reg.portAddr;
  end

  // Next-state logic; everything holds while ce is low
  always_comb begin
    state_next = state_reg;
    // Holding the copy unchanged is all that ce low needs
    if (ce) begin
      // Force error is a single-cycle strobe
      state_next.forceErr = 1'h0;

      // Pause results only count for a full-duplex common mode
      state_next.pauseRx = resRx & fullDuplexHcd;
      state_next.pauseTx = resTx & fullDuplexHcd;

      // Strap taken once, after the synchroniser has settled
      // Limitation: a direct write before the capture is overwritten by it
      if (!state_reg.strapDone) begin
        if (state_reg.strapCnt == PFC_STRAP_WAIT) begin
          state_next.portAddr = strapSync;
          state_next.strapDone = 1'h1;
        end else begin
          state_next.strapCnt = state_reg.strapCnt + 2'h1;
        end
      end

      // One ack per request, dropped the cycle after
      // Accept re-arms as soon as ack drops; a master that holds its request gets a second ack
      state_next.ack = accept;
      if (accept && !we_i) begin
        // Unmapped reads answer zero
        if (hitReg || hitBcast) begin
          state_next.rdData = {16'h0000, regView};
        end else begin
          state_next.rdData = 32'h0000_0000;
        end
      end

      // Writes land on the edge where the master samples ack
      if (wrNow && sel_i[1]) begin
        // Read-only pause and pass bits take no write data; pass only follows bit 8
        state_next.autoXo = dat_i[PFC_B_AUTO_XO];
        state_next.forceXo = dat_i[PFC_B_FORCE_XO];
        state_next.forceErr = dat_i[PFC_B_FORCE_ERR];
        state_next.seqSel = dat_i[PFC_B_SEQ_SEL];
        state_next.run = dat_i[PFC_B_RUN];
        if (!dat_i[PFC_B_RUN]) begin
          state_next.passFlag = 1'h0;
        end else if (!state_reg.run) begin
          // A fresh start arms the pass flag
          state_next.passFlag = 1'h1;
        end
      end
      if (wrNow && sel_i[0]) begin
        state_next.ledBypass = dat_i[PFC_B_LED_BYP];
        state_next.ledCnfg = dat_i[PFC_B_LED_CFG +: 2];
        // Broadcast alias never moves the port address
        if (hitReg) begin
          state_next.portAddr = dat_i[PFC_B_PORT_ADDR +: 5];
        end
      end

      // Failure is latched low and beats a same-cycle start
      if (selftestFail) begin
        state_next.passFlag = 1'h0;
      end
    end
  end

  // Single state register with synchronous reset
  // Reset ignores ce so a frozen bank still returns to its defaults
  always_ff @(posedge clk) begin
    if (rst) begin
      state_reg <= PFC_STATE_RST;
    end else begin
      state_reg <= state_next;
    end
  end

  // All outputs straight from the state register
  // No logic sits between the flop and the pin
  assign dat_o = state_reg.rdData;
  assign ack_o = state_reg.ack;
  assign autoCrossoverEnable = state_reg.autoXo;
  assign forceCrossover = state_reg.forceXo;
  assign selftestForceError = state_reg.forceErr;
  assign selftestSequenceSelect = state_reg.seqSel;
  assign selftestEnable = state_reg.run;
  assign ledStretchBypass = state_reg.ledBypass;
  assign ledConfig = state_reg.ledCnfg;
  assign portAddress = state_reg.portAddr;
  assign pauseRxEnable = state_reg.pauseRx;
  assign pauseTxEnable = state_reg.pauseTx;

  // The hold checks further down catch crossover, force error, pass, enable and
  // LED bypass moving without their own write; the write checks only prove that a write lands
  // Checks on the register behaviour
  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);

  // Write of bit 15 reaches the crossover enable
  auto_xo_write_a: assert property (
    ce && wrNow && sel_i[1] |=> autoCrossoverEnable == $past(dat_i[15]))
    else $error("auto crossover enable did not follow write");

  // Write of bit 14 reaches the forced crossing
  force_xo_write_a: assert property (
    ce && wrNow && sel_i[1] |=> forceCrossover == $past(dat_i[14]))
    else $error("force crossover did not follow write");

  // Pause receive tracks resolution and duplex
  pause_rx_res_a: assert property (
    ce |=> pauseRxEnable == $past(fullDuplexHcd &&
      ((localAdvPause[0] && partnerAdvPause[0]) ||
       (localAdvPause == 2'h3 && partnerAdvPause == 2'h2))))
    else $error("pause receive resolution wrong");

  // Pause transmit tracks resolution and duplex
  pause_tx_res_a: assert property (
    ce |=> pauseTxEnable == $past(fullDuplexHcd &&
      ((localAdvPause[0] && partnerAdvPause[0]) ||
       (localAdvPause == 2'h2 && partnerAdvPause == 2'h3))))
    else $error("pause transmit resolution wrong");

  // Force error strobe is exactly one cycle long
  force_err_pulse_a: assert property (
    ce && wrNow && sel_i[1] && dat_i[11] ##1 ce |=>
      $past(selftestForceError) && !selftestForceError)
    else $error("force error not a single pulse");

  // Failure clears the pass flag on the next edge
  pass_fail_clr_a: assert property (
    ce && selftestFail |=> !state_reg.passFlag)
    else $error("pass flag survived a failure");

  // Start arms both the engine and the pass flag
  run_start_a: assert property (
    ce && wrNow && sel_i[1] && dat_i[8] && !selftestEnable && !selftestFail
      |=> selftestEnable && state_reg.passFlag)
    else $error("start did not arm self-test");

  // Stop drops the engine and the pass flag together
  run_stop_a: assert property (
    ce && wrNow && sel_i[1] && !dat_i[8] |=> !selftestEnable && !state_reg.passFlag)
    else $error("stop did not clear self-test");

  // Readback of bit 8 needs enable and traffic
  run_readback_a: assert property (
    ce && accept && !we_i && hitReg |=>
      ack_o && dat_o[8] == ($past(selftestEnable) && $past(selftestRxTraffic)))
    else $error("run readback wrong");

  // Bypass bit reaches the LED path
  led_bypass_a: assert property (
    ce && wrNow && sel_i[0] |=> ledStretchBypass == $past(dat_i[7]))
    else $error("LED bypass did not follow write");

  // Broadcast write keeps the port address
  bcast_keep_a: assert property (
    ce && wrNow && hitBcast && state_reg.strapDone |=> $stable(portAddress))
    else $error("broadcast write changed port address");

  // One ack per request, upper half reads zero
  bus_word_a: assert property (
    ce && ack_o |=> !ack_o && dat_o[31:16] == 16'h0000)
    else $error("ack held or upper half not zero");

  // Every taken request is answered on the next edge
  ack_next_a: assert property (
    ce && accept |=> ack_o)
    else $error("request not answered on the next edge");

  // Unmapped reads return an all-zero word
  unmapped_zero_a: assert property (
    ce && accept && !we_i && !hitReg && !hitBcast |=> dat_o == 32'h0000_0000)
    else $error("unmapped read not zero");

  // Read data stands until the next read is taken
  rd_hold_a: assert property (
    ce && !(accept && !we_i) |=> $stable(dat_o))
    else $error("read data moved without a read");

  // Crossover bits move only with a high-byte write
  xo_hold_a: assert property (
    ce && !(wrNow && sel_i[1]) |=> $stable(autoCrossoverEnable) && $stable(forceCrossover))
    else $error("crossover bits moved without a write");

  // Force error never rises without its write
  force_err_idle_a: assert property (
    ce && !(wrNow && sel_i[1] && dat_i[11]) |=> !selftestForceError)
    else $error("force error rose without a write");

  // Pass flag is latched low: only a fresh start sets it
  pass_latch_a: assert property (
    ce && !state_reg.passFlag && !(wrNow && sel_i[1] && dat_i[8] && !state_reg.run)
      |=> !state_reg.passFlag)
    else $error("pass flag set without a fresh start");

  // Engine enable moves only with a high-byte write
  run_hold_a: assert property (
    ce && !(wrNow && sel_i[1]) |=> $stable(selftestEnable))
    else $error("self-test enable moved without a write");

  // LED bypass moves only with a low-byte write
  led_hold_a: assert property (
    ce && !(wrNow && sel_i[0]) |=> $stable(ledStretchBypass))
    else $error("LED bypass moved without a write");

  // Strap lands once the wait count is reached
  strap_take_a: assert property (
    ce && !state_reg.strapDone && state_reg.strapCnt == PFC_STRAP_WAIT &&
      !(wrNow && sel_i[0] && hitReg) |=> portAddress == $past(strapSync))
    else $error("strap not captured");

  // Clock enable low freezes the whole bank
  ce_freeze_a: assert property (
    !ce |=> $stable(state_reg))
    else $error("state moved while clock enable low");

  // Main scenarios
  start_seen_c: cover property (ce && wrNow && dat_i[8] ##1 selftestEnable);
  traffic_read_c: cover property (ce && accept && !we_i && hitReg &&
    selftestEnable && selftestRxTraffic);
  bcast_write_c: cover property (ce && wrNow && hitBcast);
  force_err_c: cover property (selftestForceError);
  ce_freeze_c: cover property (!ce ##1 ce);
endmodule

//--- pfc_pkg.sv
// Package with offsets, field positions, reset values and state type of the function control bank
package pfc_pkg;

  // Register index and byte address on the bus (index times four)
  localparam logic [7:0] PFC_FUNC_IDX = 8'h19;
  localparam logic [9:0] PFC_FUNC_ADDR = {PFC_FUNC_IDX, 2'h0};
  // Broadcast alias of the same register
  localparam logic [7:0] PFC_BCAST_IDX = 8'h39;
  localparam logic [9:0] PFC_BCAST_ADDR = {PFC_BCAST_IDX, 2'h0};

  // Field positions inside the 16-bit word
  localparam int PFC_B_AUTO_XO = 15;
  localparam int PFC_B_FORCE_XO = 14;
  localparam int PFC_B_PAUSE_RX = 13;
  localparam int PFC_B_PAUSE_TX = 12;
  localparam int PFC_B_FORCE_ERR = 11;
  localparam int PFC_B_SEQ_SEL = 10;
  localparam int PFC_B_PASS = 9;
  localparam int PFC_B_RUN = 8;
  localparam int PFC_B_LED_BYP = 7;
  localparam int PFC_B_LED_CFG = 5;
  localparam int PFC_B_PORT_ADDR = 0;

  // Values after reset
  localparam logic PFC_RST_AUTO_XO = 1'h1;
  localparam logic PFC_RST_OTHER = 1'h0;
  localparam logic [1:0] PFC_RST_LED_CFG = 2'h0;

  // Cycles waited after reset before the synchronised strap is taken
  localparam logic [1:0] PFC_STRAP_WAIT = 2'h3;

  // Whole state of the bank, registered in one place
  typedef struct packed {
    logic autoXo;
    logic forceXo;
    logic forceErr;
    logic seqSel;
    logic passFlag;
    logic run;
    logic ledBypass;
    logic [1:0] ledCnfg;
    logic [4:0] portAddr;
    logic pauseRx;
    logic pauseTx;
    logic [1:0] strapCnt;
    logic strapDone;
    logic ack;
    logic [31:0] rdData;
  } pfc_state_t;

endpackage

//--- pfc_sync.sv
// Two-flop synchroniser for pin-level inputs
`timescale 1ns/1ps
module pfc_sync #(
  parameter int W = 5
) (
  input wire logic clk,
  input wire logic rst,
  input wire logic ce,
  input wire logic [W-1:0] d,
  output logic [W-1:0] q
);
  // Both stages in one word; the first is read only by the second
  typedef struct packed {
    logic [W-1:0] meta;
    logic [W-1:0] held;
  } pfc_sync_state_t;

  pfc_sync_state_t state_reg; // Registered stages
  pfc_sync_state_t state_next; // Next value of the stages

  // Both stages freeze with the clock enable
  always_comb begin
    state_next = state_reg;
    if (ce) begin
      state_next.meta = d;
      state_next.held = state_reg.meta;
    end
  end

  // Single register for both stages
  always_ff @(posedge clk) begin
    if (rst) begin
      state_reg <= '0;
    end else begin
      state_reg <= state_next;
    end
  end

  // Output taps the second stage only
  assign q = state_reg.held;
endmodule

//--- pfc_selftest_model.sv
// Behavioural self-test engine facing the function control bank
`timescale 1ns/1ps
module pfc_selftest_model (
  input wire logic clk,
  input wire logic rst,
  input wire logic selftestEnable,
  input wire logic selftestForceError,
  output logic selftestRxTraffic,
  output logic selftestFail,
  output logic [7:0] errCount
);
  logic [1:0] seenCnt; // Enabled cycles before traffic shows

  // Traffic is seen a few cycles after start, not at once, and drops on stop
  always_ff @(posedge clk) begin
    if (rst || !selftestEnable) begin
      seenCnt <= 2'h0;
      selftestRxTraffic <= 1'b0;
    end else begin
      if (seenCnt != 2'h3) begin
        seenCnt <= seenCnt + 2'h1;
      end
      selftestRxTraffic <= (seenCnt == 2'h3);
    end
  end

  // Each injected error returns as one failure pulse and one count
  always_ff @(posedge clk) begin
    if (rst) begin
      selftestFail <= 1'b0;
      errCount <= 8'h00;
    end else begin
      selftestFail <= selftestForceError;
      errCount <= errCount + {7'h00, selftestForceError};
    end
  end
endmodule

//--- tb.sv
// Self-checking bench for the function control bank
`timescale 1ns/1ps
module tb;
  import pfc_pkg::*;
  logic clk = 0, rst = 1, cyc = 0, stb = 0, we = 0, ack, fd = 0, ceOn = 1;
  logic [9:0] adr = 10'h000;
  logic [3:0] sel = 4'h0;
  logic [31:0] wdat = 32'h0000_0000, rdat;
  logic [1:0] lp = 2'h0, pp = 2'h0, ledCfg;
  logic [4:0] strap = 5'h00, portAdr;
  logic xoA, xoF, fErr, seqSel, stEn, ledByp, pRx, pTx, traffic, stFail;
  logic [7:0] errCnt, errOld;
  logic [15:0] m; // Model of the writable bits
  logic run = 0, pass = 0; // Model of self-test state
  int fail_count = 0, checks = 0;

  pfc_phy_control uut (.clk(clk), .rst(rst), .ce(ceOn), .cyc_i(cyc), .stb_i(stb), .we_i(we),
    .adr_i(adr), .sel_i(sel), .dat_i(wdat), .dat_o(rdat), .ack_o(ack), .localAdvPause(lp),
    .partnerAdvPause(pp), .fullDuplexHcd(fd), .selftestFail(stFail),
    .selftestRxTraffic(traffic), .portAddressStrap(strap), .autoCrossoverEnable(xoA),
    .forceCrossover(xoF), .selftestForceError(fErr), .selftestSequenceSelect(seqSel),
    .selftestEnable(stEn), .ledStretchBypass(ledByp), .ledConfig(ledCfg),
    .portAddress(portAdr), .pauseRxEnable(pRx), .pauseTxEnable(pTx));
  pfc_selftest_model peer (.clk(clk), .rst(rst), .selftestEnable(stEn),
    .selftestForceError(fErr), .selftestRxTraffic(traffic), .selftestFail(stFail),
    .errCount(errCnt));

  // 25 MHz clock
  always #20 clk = ~clk;

  task automatic complete_run();
    $display("checks %0d fail_count %0d", checks, fail_count);
    if (fail_count == 0 && checks > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask

  // One compare for every word or output group
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checks++;
    if (got !== exp) begin
      fail_count++;
      $display("mismatch at %0t got %h exp %h", $time, got, exp);
    end
  endtask

  // Classic single Wishbone cycle; waits for ack under a bound
  task automatic wb(input logic w, input logic [9:0] a, input logic [15:0] d,
                    input logic [3:0] s, output logic [31:0] r);
    int n;
    @(posedge clk);
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= w;
    adr <= a;
    sel <= s;
    wdat <= {16'h0000, d};
    n = 0;
    do begin
      @(posedge clk);
      n++;
    end while (ack !== 1'b1 && n < 20);
    if (n >= 20) begin
      fail_count++;
      complete_run();
    end
    r = rdat;
    cyc <= 1'b0;
    stb <= 1'b0;
    @(posedge clk);
  endtask

  // Expected read word: pause resolved only in full duplex
  function automatic logic [31:0] expw();
    logic rx, tx;
    rx = fd & ((lp[0] & pp[0]) | (lp[0] & lp[1] & !pp[0] & pp[1]));
    tx = fd & ((lp[0] & pp[0]) | (!lp[0] & lp[1] & pp[0] & pp[1]));
    return {16'h0000, m[15:14], rx, tx, 1'b0, m[10], pass, run, m[7:0]};
  endfunction

  task automatic rdchk(input logic [9:0] a, input logic [31:0] exp);
    logic [31:0] r;
    wb(1'b0, a, 16'h0000, 4'hF, r);
    chk(r, exp);
  endtask

  // Update the model, then write; broadcast keeps the port address
  task automatic mwrite(input logic [9:0] a, input logic [15:0] d, input logic [3:0] s);
    logic [31:0] r;
    if (a == PFC_FUNC_ADDR || a == PFC_BCAST_ADDR) begin
      if (s[1]) begin
        m[15:8] = d[15:8] & 8'hC4;
        if (d[8] && !run) pass = 1;
        if (!d[8] || d[11]) pass = 0;
        run = d[8];
      end
      if (s[0]) m[7:0] = (a == PFC_BCAST_ADDR) ? {d[7:5], m[4:0]} : d[7:0];
    end
    wb(1'b1, a, d, s, r);
  endtask

  task automatic chkout();
    chk({20'h0_0000, xoA, xoF, seqSel, stEn, ledByp, ledCfg, portAdr},
        {20'h0_0000, m[15], m[14], m[10], run, m[7], m[6:5], m[4:0]});
  endtask

  initial begin
    logic [9:0] a;
    logic [31:0] e;
    void'($urandom(50649));
    strap <= 5'($urandom);
    repeat (6) @(posedge clk);
    rst <= 1'b0;
    repeat (8) @(posedge clk);
    m = {8'h80, 3'h0, strap};
    chkout();
    rdchk(PFC_FUNC_ADDR, expw());
    // Unmapped place: write ignored, reads zero
    mwrite(10'h068, 16'hFFFF, 4'hF);
    rdchk(10'h068, 32'h0000_0000);
    rdchk(PFC_FUNC_ADDR, expw());
    // Random writes over both aliases; read-only bits set in the data
    for (int i = 0; i < 12; i++) begin
      a = ($urandom_range(0, 1) == 0) ? PFC_FUNC_ADDR : PFC_BCAST_ADDR;
      mwrite(a, 16'($urandom) & 16'hF6FF, 4'($urandom));
      rdchk(PFC_FUNC_ADDR, expw());
      chkout();
    end
    // Clock enable low freezes the bank while the pause inputs move
    e = expw();
    ceOn <= 1'b0;
    {fd, lp, pp} <= 5'h1F;
    repeat (4) @(posedge clk);
    chk({30'h0000_0000, pRx, pTx}, {30'h0000_0000, e[13:12]});
    chkout();
    ceOn <= 1'b1;
    // Every pause input combination
    for (int i = 0; i < 32; i++) begin
      {fd, lp, pp} <= 5'(i);
      repeat (2) @(posedge clk);
      e = expw();
      chk({30'h0000_0000, pRx, pTx}, {30'h0000_0000, e[13:12]});
      rdchk(PFC_FUNC_ADDR, expw());
    end
    // Start, wait for traffic, inject one error, stop
    for (int k = 0; k < 2; k++) begin
      mwrite(PFC_FUNC_ADDR, {m[15:11], 1'(k), 2'h1, m[7:0]}, 4'h2);
      repeat (8) @(posedge clk);
      chkout();
      rdchk(PFC_FUNC_ADDR, expw());
      errOld = errCnt;
      mwrite(PFC_FUNC_ADDR, {m[15:12], 1'b1, m[10], 2'h1, m[7:0]}, 4'h2);
      repeat (3) @(posedge clk);
      chk({24'h00_0000, errCnt - errOld}, 32'h0000_0001);
      rdchk(PFC_FUNC_ADDR, expw());
      mwrite(PFC_FUNC_ADDR, {m[15:9], 1'b0, m[7:0]}, 4'h2);
      rdchk(PFC_FUNC_ADDR, expw());
      mwrite(PFC_FUNC_ADDR, {m[15:9], 1'b1, m[7:0]}, 4'h2);
      rdchk(PFC_FUNC_ADDR, expw() & 32'h0000_FEFF);
      mwrite(PFC_FUNC_ADDR, {m[15:9], 1'b0, m[7:0]}, 4'h2);
      rdchk(PFC_FUNC_ADDR, expw());
    end
    complete_run();
  end
endmodule
